// *** logic/prw_pkg.sv ***
package prw_pkg;

    localparam int NUM_WIN = 6;

    // byte offsets of the window registers
    localparam logic [11:0] OFF_C0_LMMIO_START = 12'h008;
    localparam logic [11:0] OFF_C0_LMMIO_END = 12'h00c;
    localparam logic [11:0] OFF_C0_CFG_START = 12'h020;
    localparam logic [11:0] OFF_C0_CFG_END = 12'h024;
    localparam logic [11:0] OFF_C0_E2_START = 12'h028;
    localparam logic [11:0] OFF_C0_E2_END = 12'h02c;
    localparam logic [11:0] OFF_C0_E2_FINE = 12'h030;
    localparam logic [11:0] OFF_C1_E1_START = 12'h100;
    localparam logic [11:0] OFF_C1_E1_END = 12'h104;
    localparam logic [11:0] OFF_C1_LMMIO_START = 12'h108;
    localparam logic [11:0] OFF_C1_LMMIO_END = 12'h10c;
    localparam logic [11:0] OFF_C1_HMMIO_START = 12'h110;
    localparam logic [11:0] OFF_C1_HMMIO_END = 12'h114;

    // window indices
    localparam logic [2:0] WIN_C0_LMMIO = 3'h0;
    localparam logic [2:0] WIN_C0_CFG = 3'h1;
    localparam logic [2:0] WIN_C0_E2 = 3'h2;
    localparam logic [2:0] WIN_C1_E1 = 3'h3;
    localparam logic [2:0] WIN_C1_LMMIO = 3'h4;
    localparam logic [2:0] WIN_C1_HMMIO = 3'h5;

    // field positions
    localparam int START_OPEN_BIT = 29;
    localparam int START_BASE_MSB = 28;
    localparam int START_BASE_LSB = 1;
    localparam int START_VALID_BIT = 0;
    localparam int END_LIMIT_MSB = 27;
    localparam int FINE_START_MSB = 9;
    localparam int FINE_START_LSB = 5;
    localparam int FINE_END_MSB = 4;
    localparam int FINE_END_LSB = 0;

    // reset values
    localparam logic [29:0] START_RST = 30'h0;
    localparam logic [27:0] END_RST = 28'h0;
    localparam logic [9:0] FINE_RST = 10'h0;

    typedef struct packed {
        logic open;           // 1: non-secure window, passes all
        logic [27:0] base;    // start address bits 47..20
        logic valid;
    } prw_start_t;

    typedef struct packed {
        prw_start_t start;
        logic [27:0] limit;   // end address bits 47..20
    } prw_win_t;

    typedef struct packed {
        logic [4:0] startFine; // ecam2 start bits 19..15
        logic [4:0] endFine;   // ecam2 end bits 19..15
    } prw_fine_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } prw_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [47:0] addr;
        logic secure;
    } prw_look_req_t;

    typedef struct packed {
        logic valid;
        logic [NUM_WIN-1:0] hit;
        logic [NUM_WIN-1:0] blocked;
        logic allowed;
    } prw_look_rsp_t;

    typedef enum logic [1:0] {KIND_NONE, KIND_START, KIND_END, KIND_FINE}
        prw_kind_t;

    typedef struct packed {
        prw_kind_t kind;
        logic [2:0] idx;
    } prw_dec_t;

    function automatic prw_dec_t prw_decode(logic [11:0] addr);
        prw_dec_t r;
        r.kind = KIND_NONE;
        r.idx = 3'h0;
        case (addr)
            OFF_C0_LMMIO_START: r = '{KIND_START, WIN_C0_LMMIO};
            OFF_C0_LMMIO_END: r = '{KIND_END, WIN_C0_LMMIO};
            OFF_C0_CFG_START: r = '{KIND_START, WIN_C0_CFG};
            OFF_C0_CFG_END: r = '{KIND_END, WIN_C0_CFG};
            OFF_C0_E2_START: r = '{KIND_START, WIN_C0_E2};
            OFF_C0_E2_END: r = '{KIND_END, WIN_C0_E2};
            OFF_C0_E2_FINE: r = '{KIND_FINE, WIN_C0_E2};
            OFF_C1_E1_START: r = '{KIND_START, WIN_C1_E1}; // R10
            OFF_C1_E1_END: r = '{KIND_END, WIN_C1_E1};
            OFF_C1_LMMIO_START: r = '{KIND_START, WIN_C1_LMMIO};
            OFF_C1_LMMIO_END: r = '{KIND_END, WIN_C1_LMMIO};
            OFF_C1_HMMIO_START: r = '{KIND_START, WIN_C1_HMMIO};
            OFF_C1_HMMIO_END: r = '{KIND_END, WIN_C1_HMMIO};
            default: r = '{KIND_NONE, 3'h0};
        endcase
        return r;
    endfunction : prw_decode

endpackage : prw_pkg

// *** logic/prw_rd_mux.sv ***
`timescale 1ns/100ps
module prw_rd_mux import prw_pkg::*; (
    input wire prw_win_t [NUM_WIN-1:0] wins, // programmed windows
    input wire prw_fine_t fine,              // ecam2 fine bounds
    input wire logic [11:0] addr,            // register byte address
    output logic [31:0] data                 // read value, zero if unmapped
);
    prw_dec_t dec;

    always_comb begin
        dec = prw_decode(addr);
        data = 32'h0;
        case (dec.kind)
            KIND_START: data = {2'h0, wins[dec.idx].start};   // R5
            KIND_END: data = {4'h0, wins[dec.idx].limit};     // R5
            KIND_FINE: data = {22'h0, fine};                  // R5
            default: data = 32'h0;
        endcase
    end

endmodule : prw_rd_mux

// *** logic/prw_win_match.sv ***
`timescale 1ns/100ps
module prw_win_match import prw_pkg::*; (
    input wire prw_win_t win,          // one window's registers
    input wire logic useFine,          // take bits 19..15 from fine bounds
    input wire prw_fine_t fine,        // fine bounds
    input wire logic [47:0] addr,      // address under test
    input wire logic secure,           // access is secure
    output logic hit,                  // address lies in a valid window
    output logic blocked               // hit but refused for security
);
    logic [47:0] lo;
    logic [47:0] hi;

    always_comb begin
        // the end is inclusive up to the last byte of its granule
        lo = {win.start.base, useFine ? fine.startFine : 5'h00, 15'h0000}; // R8
        hi = {win.limit, useFine ? fine.endFine : 5'h1f, 15'h7fff};        // R8
        hit = win.start.valid && addr >= lo && addr <= hi;                 // R12
        blocked = hit && !win.start.open && !secure;                       // R1
    end

endmodule : prw_win_match

// *** logic/prw_window_regs.sv ***
// Contract
// [R1] A start register's bit 29 set opens the window to all accesses; clear passes only secure ones.
// [R2] Start register bits 28..1 hold start address bits 47..20, read/write, reset zero.
// [R3] Start register bit 0 marks the window valid and resets to zero.
// [R4] End register bits 27..0 hold end address bits 47..20, read/write.
// [R5] Reserved upper bits read as zero and ignore writes.
// [R6] Fine-bounds bits 9..5 give the ecam2 start address bits 19..15, reset zero.
// [R7] Fine-bounds bits 4..0 give the ecam2 end address bits 19..15, reset zero.
// [R8] The ecam2 bounds join coarse bits 47..20 with fine bits 19..15.
// [R9] Every register of the bank is always present.
// [R10] The second controller has its own window set, apart from the first.
// [R11] The first controller's low mmio start register sits at 0x008 with the start layout.
// [R12] An address hits only a valid window between start and end inclusive, secure windows refuse non-secure access.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
module prw_window_regs import prw_pkg::*; (
    input wire logic clk,                 // 200 MHz clock
    input wire logic nrst,                // async reset, active low
    input wire prw_bus_req_t busReq,      // register port request
    output logic [31:0] rdData,           // read data, cycle after read
    input wire prw_look_req_t lookReq,    // address check request
    output prw_look_rsp_t lookRsp,        // address check answer
    output prw_win_t [NUM_WIN-1:0] winCfg, // programmed windows
    output prw_fine_t fineCfg             // ecam2 fine bounds
);

    typedef struct packed {
        prw_win_t [NUM_WIN-1:0] win;
        prw_fine_t fine;
        logic [31:0] rdData;
        prw_look_rsp_t rsp;
    } prw_state_t;

    prw_state_t state_q;
    prw_state_t state_d;
    prw_dec_t wrDec;
    logic [31:0] muxData;
    logic [NUM_WIN-1:0] hitNow;
    logic [NUM_WIN-1:0] blockNow;

    prw_rd_mux u_rd_mux (
        .wins(state_q.win),
        .fine(state_q.fine),
        .addr(busReq.addr),
        .data(muxData)
    );

    // one matcher per window; only the ecam2 window uses fine bounds
    for (genvar i = 0; i < NUM_WIN; i++) begin : g_match
        prw_win_match u_match (
            .win(state_q.win[i]),
            .useFine(3'(i) == WIN_C0_E2),
            .fine(state_q.fine),
            .addr(lookReq.addr),
            .secure(lookReq.secure),
            .hit(hitNow[i]),
            .blocked(blockNow[i])
        );
    end

    always_comb begin
        state_d = state_q;
        wrDec = prw_decode(busReq.addr);
        // all windows are fixed hardware, none can be configured away
        if (busReq.wr) begin // R9
            case (wrDec.kind)
                KIND_START: begin
                    // bits 31..30 are dropped here
                    state_d.win[wrDec.idx].start =
                        busReq.wdata[START_OPEN_BIT:START_VALID_BIT]; // R1 R2 R3 R11
                end
                KIND_END: begin
                    state_d.win[wrDec.idx].limit =
                        busReq.wdata[END_LIMIT_MSB:0]; // R4 R5
                end
                KIND_FINE: begin
                    state_d.fine.startFine =
                        busReq.wdata[FINE_START_MSB:FINE_START_LSB]; // R6
                    state_d.fine.endFine =
                        busReq.wdata[FINE_END_MSB:FINE_END_LSB]; // R7
                end
                default: begin
                end
            endcase
        end
        // data stand for one cycle only, zero otherwise
        state_d.rdData = busReq.rd ? muxData : 32'h0; // R5
        // answers use the registers as they stood in the request cycle
        state_d.rsp.valid = lookReq.valid;
        state_d.rsp.hit = lookReq.valid ? hitNow : '0; // R12
        state_d.rsp.blocked = lookReq.valid ? blockNow : '0; // R1
        state_d.rsp.allowed = lookReq.valid && |(hitNow & ~blockNow); // R12
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_WIN; i++) begin
                state_q.win[i].start <= START_RST; // R3
                state_q.win[i].limit <= END_RST;
            end
            state_q.fine <= FINE_RST;
            state_q.rdData <= 32'h0;
            state_q.rsp <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
    assign lookRsp = state_q.rsp;
    assign winCfg = state_q.win;
    assign fineCfg = state_q.fine;

    // assertions
    sequence s_wrThenRd(logic [11:0] off);
        busReq.wr && busReq.addr == off ##1 busReq.rd && busReq.addr == off;
    endsequence

    property p_lowMmioStartRw;
        @(posedge clk) disable iff (!nrst)
        s_wrThenRd(OFF_C0_LMMIO_START) |=>
            rdData == {2'h0, $past(busReq.wdata[29:0], 2)};
    endproperty
    a_lowMmioStartRw: assert property (p_lowMmioStartRw) // R2 R11
        else $error("low mmio start read back wrong");

    property p_endRw;
        @(posedge clk) disable iff (!nrst)
        s_wrThenRd(OFF_C1_E1_END) |=>
            rdData == {4'h0, $past(busReq.wdata[27:0], 2)};
    endproperty
    a_endRw: assert property (p_endRw) // R4
        else $error("end register read back wrong");

    property p_fineRw;
        @(posedge clk) disable iff (!nrst)
        s_wrThenRd(OFF_C0_E2_FINE) |=>
            rdData == {22'h0, $past(busReq.wdata[9:0], 2)};
    endproperty
    a_fineRw: assert property (p_fineRw) // R6 R7
        else $error("fine bounds read back wrong");

    property p_startRsvd;
        @(posedge clk) disable iff (!nrst)
        busReq.rd && wrDec.kind == KIND_START |=>
            rdData[31:30] == 2'h0;
    endproperty
    a_startRsvd: assert property (p_startRsvd) // R5
        else $error("start reserved bits not zero");

    property p_unmappedZero;
        @(posedge clk) disable iff (!nrst)
        !busReq.rd || wrDec.kind == KIND_NONE |=>
            rdData == 32'h0;
    endproperty
    a_unmappedZero: assert property (p_unmappedZero) // R5
        else $error("read data not zero outside a mapped read");

    property p_invalidNoHit;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && !state_q.win[WIN_C1_LMMIO].start.valid |=>
            lookRsp.valid && !lookRsp.hit[WIN_C1_LMMIO];
    endproperty
    a_invalidNoHit: assert property (p_invalidNoHit) // R3 R12
        else $error("invalid window reported a hit");

    property p_secureRefuse;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && !lookReq.secure && hitNow[WIN_C0_CFG]
            && !state_q.win[WIN_C0_CFG].start.open |=>
            lookRsp.blocked[WIN_C0_CFG];
    endproperty
    a_secureRefuse: assert property (p_secureRefuse) // R1
        else $error("non-secure access to secure window not refused");

    property p_openPass;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && hitNow[WIN_C1_HMMIO]
            && state_q.win[WIN_C1_HMMIO].start.open |=>
            lookRsp.allowed && !lookRsp.blocked[WIN_C1_HMMIO];
    endproperty
    a_openPass: assert property (p_openPass) // R1
        else $error("open window refused an access");

    property p_ecam2Edge;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && state_q.win[WIN_C0_E2].start.valid
            && lookReq.addr == {state_q.win[WIN_C0_E2].start.base,
                                state_q.fine.startFine, 15'h0000}
            && {state_q.win[WIN_C0_E2].limit, state_q.fine.endFine}
               >= {state_q.win[WIN_C0_E2].start.base,
                   state_q.fine.startFine} |=>
            lookRsp.hit[WIN_C0_E2];
    endproperty
    a_ecam2Edge: assert property (p_ecam2Edge) // R8
        else $error("ecam2 start granule not hit");

    property p_ctlIndep;
        @(posedge clk) disable iff (!nrst)
        busReq.wr && busReq.addr >= OFF_C1_E1_START |=>
            $stable(state_q.win[WIN_C0_E2:WIN_C0_LMMIO])
            && $stable(state_q.fine);
    endproperty
    a_ctlIndep: assert property (p_ctlIndep) // R10
        else $error("second controller write changed first controller");

    sequence s_onePulse;
        lookReq.valid ##1 !lookReq.valid;
    endsequence

    property p_rspPulse;
        @(posedge clk) disable iff (!nrst)
        s_onePulse |-> lookRsp.valid ##1 !lookRsp.valid;
    endproperty
    a_rspPulse: assert property (p_rspPulse) // R12
        else $error("check answer not one cycle after request");

    property p_endRsvd;
        @(posedge clk) disable iff (!nrst)
        busReq.rd && wrDec.kind == KIND_END |=>
            rdData[31:28] == 4'h0;
    endproperty
    a_endRsvd: assert property (p_endRsvd) // R5
        else $error("end reserved bits not zero");

    property p_fineRsvd;
        @(posedge clk) disable iff (!nrst)
        busReq.rd && wrDec.kind == KIND_FINE |=>
            rdData[31:10] == 22'h0;
    endproperty
    a_fineRsvd: assert property (p_fineRsvd) // R5
        else $error("fine bounds reserved bits not zero");

    property p_wrNoneIgnored;
        @(posedge clk) disable iff (!nrst)
        busReq.wr && wrDec.kind == KIND_NONE |=>
            $stable(state_q.win) && $stable(state_q.fine);
    endproperty
    a_wrNoneIgnored: assert property (p_wrNoneIgnored) // R5
        else $error("write to unmapped address changed the bank");

    property p_c0Indep;
        @(posedge clk) disable iff (!nrst)
        busReq.wr && busReq.addr < OFF_C1_E1_START |=>
            $stable(state_q.win[WIN_C1_HMMIO:WIN_C1_E1]);
    endproperty
    a_c0Indep: assert property (p_c0Indep) // R10
        else $error("first controller write changed second controller");

    property p_startWrite;
        @(posedge clk) disable iff (!nrst)
        busReq.wr && busReq.addr == OFF_C1_HMMIO_START |=>
            state_q.win[WIN_C1_HMMIO].start == $past(busReq.wdata[29:0])
            && $stable(state_q.win[WIN_C1_HMMIO].limit);
    endproperty
    a_startWrite: assert property (p_startWrite) // R1 R2 R3
        else $error("start write did not land alone");

    property p_secureNeverBlocked;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && lookReq.secure |=> lookRsp.blocked == '0;
    endproperty
    a_secureNeverBlocked: assert property (p_secureNeverBlocked) // R1
        else $error("secure access was refused");

    property p_idleRspZero;
        @(posedge clk) disable iff (!nrst)
        !lookReq.valid |=> lookRsp == '0;
    endproperty
    a_idleRspZero: assert property (p_idleRspZero) // R12
        else $error("check answer without a request");

    // no disable here: the check is about reset itself
    property p_resetClear;
        @(posedge clk)
        !nrst |=> winCfg == '0 && fineCfg == '0 && rdData == 32'h0
            && lookRsp == '0;
    endproperty
    a_resetClear: assert property (p_resetClear) // R2 R3 R6 R7
        else $error("bank not cleared by reset");

    property p_e2Below;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && lookReq.addr[47:15]
            < {state_q.win[WIN_C0_E2].start.base, state_q.fine.startFine} |=>
            !lookRsp.hit[WIN_C0_E2];
    endproperty
    a_e2Below: assert property (p_e2Below) // R8
        else $error("address below ecam2 start hit the window");

    property p_e2Above;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && lookReq.addr[47:15]
            > {state_q.win[WIN_C0_E2].limit, state_q.fine.endFine} |=>
            !lookRsp.hit[WIN_C0_E2];
    endproperty
    a_e2Above: assert property (p_e2Above) // R8
        else $error("address above ecam2 end hit the window");

    property p_e2Last;
        @(posedge clk) disable iff (!nrst)
        lookReq.valid && state_q.win[WIN_C0_E2].start.valid
            && lookReq.addr == {state_q.win[WIN_C0_E2].limit,
                                state_q.fine.endFine, 15'h7fff}
            && {state_q.win[WIN_C0_E2].limit, state_q.fine.endFine}
               >= {state_q.win[WIN_C0_E2].start.base,
                   state_q.fine.startFine} |=>
            lookRsp.hit[WIN_C0_E2];
    endproperty
    a_e2Last: assert property (p_e2Last) // R8
        else $error("ecam2 last byte not hit");

endmodule : prw_window_regs

// *** testbench/prw_lookup_agent.sv ***
`timescale 1ns/100ps
module prw_lookup_agent import prw_pkg::*; (
    input wire logic clk,              // bench clock
    output prw_look_req_t lookReq,     // address check request
    input wire prw_look_rsp_t lookRsp  // answer one cycle later
);
    initial lookReq = '0;

    // one check per call; the answer stands for one cycle only
    task automatic look(input logic [47:0] a, input logic s,
                        output prw_look_rsp_t r);
        lookReq <= '{1'b1, a, s};
        @(posedge clk);
        lookReq <= '0;
        #1;
        r = lookRsp;
        @(posedge clk);
    endtask : look
endmodule : prw_lookup_agent

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb import prw_pkg::*;;
    localparam logic [11:0] OFFS [13] = '{OFF_C0_LMMIO_START,
        OFF_C0_LMMIO_END, OFF_C0_CFG_START, OFF_C0_CFG_END, OFF_C0_E2_START,
        OFF_C0_E2_END, OFF_C0_E2_FINE, OFF_C1_E1_START, OFF_C1_E1_END,
        OFF_C1_LMMIO_START, OFF_C1_LMMIO_END, OFF_C1_HMMIO_START,
        OFF_C1_HMMIO_END};
    localparam logic [31:0] MS = 32'h3fff_ffff;
    localparam logic [31:0] ME = 32'h0fff_ffff;
    localparam logic [31:0] MASKS [13] = '{MS, ME, MS, ME, MS, ME,
        32'h0000_03ff, MS, ME, MS, ME, MS, ME};

    logic clk = 1'b0;
    logic nrst = 1'b0;
    prw_bus_req_t busReq = '0;
    logic [31:0] rdData;
    prw_look_req_t lookReq;
    prw_look_rsp_t lookRsp;
    prw_win_t [NUM_WIN-1:0] winCfgOut;
    prw_fine_t fineCfgOut;
    int err_total = 0;
    int total_checks = 0;

    always #2.5 clk = ~clk;

    prw_window_regs uut (
        .clk(clk),
        .nrst(nrst),
        .busReq(busReq),
        .rdData(rdData),
        .lookReq(lookReq),
        .lookRsp(lookRsp),
        .winCfg(winCfgOut),
        .fineCfg(fineCfgOut)
    );

    prw_lookup_agent agent (
        .clk(clk),
        .lookReq(lookReq),
        .lookRsp(lookRsp)
    );

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // the write strobe is left up; the next request or idle replaces it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        busReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
    endtask : wr

    task automatic idle;
        busReq <= '0;
        @(posedge clk);
    endtask : idle

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        busReq <= '{1'b0, 1'b1, a, 32'h0};
        @(posedge clk);
        busReq <= '0;
        #1;
        chk(rdData, exp);
        @(posedge clk);
    endtask : rdchk

    task automatic lk(input logic [47:0] a, input logic s,
                      input logic [5:0] h, input logic [5:0] b,
                      input logic al);
        prw_look_rsp_t r;
        agent.look(a, s, r);
        chk({18'h0, r}, {18'h0, 1'b1, h, b, al});
    endtask : lk

    function automatic logic [31:0] pat(input int i);
        return 32'h5a3c_96e1 ^ {i[7:0], 16'h0, i[7:0]};
    endfunction : pat

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 13; i++) rdchk(OFFS[i], 32'h0);
        // read straight after write, no gap
        for (int i = 0; i < 13; i++) begin
            wr(OFFS[i], 32'hffff_ffff);
            rdchk(OFFS[i], MASKS[i]);
        end
        // all written before any read so that crosstalk would show
        for (int i = 0; i < 13; i++) wr(OFFS[i], pat(i));
        idle;
        for (int i = 0; i < 13; i++) rdchk(OFFS[i], pat(i) & MASKS[i]);
        chk({22'h0, fineCfgOut}, pat(6) & 32'h3ff);
        wr(12'h034, 32'hffff_ffff);
        rdchk(12'h034, 32'h0);
        rdchk(12'hffc, 32'h0);
        for (int i = 0; i < 13; i++) wr(OFFS[i], 32'h0);
        idle;
        wr(OFF_C0_LMMIO_START, {3'h0, 28'h10, 1'b1});
        wr(OFF_C0_LMMIO_END, {4'h0, 28'h10});
        idle;
        lk({28'h10, 20'h0}, 1'b1, 6'h01, 6'h00, 1'b1);
        lk({28'h10, 20'hfffff}, 1'b0, 6'h01, 6'h01, 1'b0);
        lk({28'h0f, 20'hfffff}, 1'b1, 6'h00, 6'h00, 1'b0);
        lk({28'h11, 20'h0}, 1'b1, 6'h00, 6'h00, 1'b0);
        wr(OFF_C0_LMMIO_START, {3'h1, 28'h10, 1'b1});
        idle;
        lk({28'h10, 20'h0}, 1'b0, 6'h01, 6'h00, 1'b1);
        wr(OFF_C0_LMMIO_START, {3'h1, 28'h10, 1'b0});
        idle;
        lk({28'h10, 20'h0}, 1'b1, 6'h00, 6'h00, 1'b0);
        wr(OFF_C0_E2_START, {3'h1, 28'h20, 1'b1});
        wr(OFF_C0_E2_END, {4'h0, 28'h20});
        wr(OFF_C0_E2_FINE, {22'h0, 5'h04, 5'h08});
        idle;
        lk({28'h20, 5'h03, 15'h7fff}, 1'b0, 6'h00, 6'h00, 1'b0);
        lk({28'h20, 5'h04, 15'h0}, 1'b0, 6'h04, 6'h00, 1'b1);
        lk({28'h20, 5'h08, 15'h7fff}, 1'b0, 6'h04, 6'h00, 1'b1);
        lk({28'h20, 5'h09, 15'h0}, 1'b0, 6'h00, 6'h00, 1'b0);
        wr(OFF_C0_CFG_START, {3'h0, 28'h30, 1'b1});
        wr(OFF_C0_CFG_END, {4'h0, 28'h30});
        wr(OFF_C1_HMMIO_START, {3'h1, 28'h40, 1'b1});
        wr(OFF_C1_HMMIO_END, {4'h0, 28'h40});
        idle;
        lk({28'h30, 20'h0}, 1'b0, 6'h02, 6'h02, 1'b0);
        lk({28'h40, 20'hfffff}, 1'b0, 6'h20, 6'h00, 1'b1);
        chk({4'h0, winCfgOut[WIN_C1_HMMIO].limit}, 32'h40);
        chk({2'h0, winCfgOut[WIN_C1_HMMIO].start}, 32'h2000_0081);
        // second reset in mid-run must clear the bank again
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdchk(OFF_C0_E2_FINE, 32'h0);
        rdchk(OFF_C0_E2_START, 32'h0);
        print_verdict;
    end

    initial begin
        #100000;
        err_total++;
        print_verdict;
    end
endmodule : tb
